// >>> include/fumc_map.svh
`ifndef FUMC_MAP_SVH
`define FUMC_MAP_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define FUMC_ADDR_W 8
`define FUMC_OFS_MODE 8'h00
`define FUMC_OFS_LOW_BLOCK 8'h04
`define FUMC_OFS_STATUS 8'h08

// ****************************************************************
// Reset values.
// ****************************************************************
`define FUMC_MODE_RESET 8'h00
`define FUMC_LOW_BLOCK_RESET 8'h00
`define FUMC_BYTE_ZERO 8'h00

// ****************************************************************
// Field positions.
// ****************************************************************
`define FUMC_BIT_ERROR 7
`define FUMC_BIT_SWE 6
`define FUMC_BIT_ESU 5
`define FUMC_BIT_PSU 4
`define FUMC_BIT_EV 3
`define FUMC_BIT_PV 2
`define FUMC_BIT_E 1
`define FUMC_BIT_P 0
`define FUMC_BIT_STAT_HWE 7
`define FUMC_BIT_STAT_CLR 0

`endif

// >>> include/fumc_pkg.sv
package fumc_pkg;

	// ****************************************************************
	// Shared types.
	// ****************************************************************
	typedef logic [7:0] fumc_byte_t;

	typedef enum logic [1:0]
	{
		FUMC_OKAY = 2'h0,
		FUMC_SLVERR = 2'h2
	} fumc_resp_t;

endpackage

// >>> rtl/fumc_onehot_guard.sv
`timescale 1ns/100ps

module fumc_onehot_guard
	import fumc_pkg::*;
(
	// Selects of both block registers.
	input wire logic [15:0] i_selects,
	// More than one select set.
	output logic o_multi
);

	logic [15:0] less_one;

	// Clearing the lowest set bit leaves something only if two or more were set.
	assign less_one = i_selects - 16'h0001;
	assign o_multi = |(i_selects & less_one);

endmodule

// >>> rtl/fumc_axil_slave.sv
`timescale 1ns/100ps
`include "fumc_map.svh"

module fumc_axil_slave
	import fumc_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	// Write address and data channels.
	input wire logic i_awvalid,
	input wire logic [`FUMC_ADDR_W-1:0] i_awaddr,
	output logic o_awready,
	input wire logic i_wvalid,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_wready,
	// Write response channel.
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	input wire logic i_bready,
	// Read channels.
	input wire logic i_arvalid,
	input wire logic [`FUMC_ADDR_W-1:0] i_araddr,
	output logic o_arready,
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_rready,
	// Core side.
	output logic o_wr_en,
	output logic [`FUMC_ADDR_W-1:0] o_wr_addr,
	output fumc_byte_t o_wr_data,
	output logic o_wr_strb,
	input fumc_resp_t i_wr_resp,
	output logic o_rd_en,
	output logic [`FUMC_ADDR_W-1:0] o_rd_addr,
	input fumc_byte_t i_rd_data,
	input fumc_resp_t i_rd_resp
);

	logic aw_held_reg;
	logic w_held_reg;
	logic bvalid_reg;
	logic rvalid_reg;
	logic awready_reg;
	logic wready_reg;
	logic arready_reg;
	logic wstrb_reg;
	logic [`FUMC_ADDR_W-1:0] awaddr_reg;
	fumc_byte_t wdata_reg;
	fumc_byte_t rdata_reg;
	fumc_resp_t bresp_reg;
	fumc_resp_t rresp_reg;
	wire aw_fire;
	wire w_fire;
	wire wr_fire;
	wire ar_fire;
	wire aw_held_next;
	wire w_held_next;
	wire bvalid_next;
	wire rvalid_next;

	// ****************************************************************
	// Handshake decode.
	// ****************************************************************
	assign aw_fire = i_awvalid && awready_reg;
	assign w_fire = i_wvalid && wready_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign ar_fire = i_arvalid && arready_reg;
	assign aw_held_next = (aw_held_reg || aw_fire) && !wr_fire;
	assign w_held_next = (w_held_reg || w_fire) && !wr_fire;
	assign bvalid_next = wr_fire || (bvalid_reg && !i_bready);
	assign rvalid_next = ar_fire || (rvalid_reg && !i_rready);

	// ****************************************************************
	// Channel state.
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			awready_reg <= !aw_held_next && !bvalid_next;
			wready_reg <= !w_held_next && !bvalid_next;
			arready_reg <= !rvalid_next;
		end
	end

	// ****************************************************************
	// Payload capture.
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			awaddr_reg <= `FUMC_OFS_MODE;
			wdata_reg <= `FUMC_BYTE_ZERO;
			wstrb_reg <= 1'b0;
			rdata_reg <= `FUMC_BYTE_ZERO;
			bresp_reg <= FUMC_OKAY;
			rresp_reg <= FUMC_OKAY;
		end
		else if (i_clk_en)
		begin
			if (aw_fire)
				awaddr_reg <= i_awaddr;
			if (w_fire)
			begin
				wdata_reg <= i_wdata[7:0];
				wstrb_reg <= i_wstrb[0];
			end
			if (wr_fire)
				bresp_reg <= i_wr_resp;
			if (ar_fire)
			begin
				rdata_reg <= i_rd_data;
				rresp_reg <= i_rd_resp;
			end
		end
	end

	assign o_awready = awready_reg;
	assign o_wready = wready_reg;
	assign o_arready = arready_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rresp = rresp_reg;
	assign o_rdata = {24'h000000, rdata_reg};
	assign o_wr_en = wr_fire;
	assign o_wr_addr = awaddr_reg;
	assign o_wr_data = wdata_reg;
	assign o_wr_strb = wstrb_reg;
	assign o_rd_en = ar_fire;
	assign o_rd_addr = i_araddr;

endmodule

// >>> rtl/fumc_top.sv
`timescale 1ns/100ps
`include "fumc_map.svh"

module fumc_top
	import fumc_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	// AXI4-Lite write channels.
	input wire logic i_awvalid,
	input wire logic [`FUMC_ADDR_W-1:0] i_awaddr,
	output logic o_awready,
	input wire logic i_wvalid,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_wready,
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	input wire logic i_bready,
	// AXI4-Lite read channels.
	input wire logic i_arvalid,
	input wire logic [`FUMC_ADDR_W-1:0] i_araddr,
	output logic o_arready,
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_rready,
	// Chip state.
	input wire logic i_write_enable_pin,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic i_flash_disabled,
	input wire logic i_op_fail,
	// Neighbouring registers.
	input wire logic i_lower_sw_enable,
	input wire logic [7:0] i_high_block_select,
	// Flash array control.
	output logic [7:0] o_upper_mode,
	output logic [7:0] o_low_block_select,
	output logic o_error_protect,
	output logic o_clear_both,
	output logic o_hold_high_nibble
);

	fumc_byte_t mode_reg;
	fumc_byte_t mode_next;
	fumc_byte_t low_reg;
	fumc_byte_t low_next;
	logic clear_both_reg;
	logic hold_high_reg;
	logic wr_en;
	logic wr_strb;
	logic rd_en;
	logic multi;
	logic [`FUMC_ADDR_W-1:0] wr_addr;
	logic [`FUMC_ADDR_W-1:0] rd_addr;
	fumc_byte_t wr_data;
	fumc_byte_t rd_data;
	fumc_resp_t rd_resp;
	fumc_resp_t wr_resp;
	logic [5:0] bit_wr_ok;
	logic [5:0] bit_kill;
	logic [5:0] mode_low_next;
	wire pin;
	wire err;
	wire swe;
	wire esu;
	wire psu;
	wire mode_wr;
	wire low_wr;
	wire swe_wr_ok;
	wire setup_wr_ok;
	wire mode_clear;
	wire err_next;
	wire swe_next;
	wire low_clear;
	wire low_wr_ok;
	wire rd_mapped;
	wire wr_mapped;

	// ****************************************************************
	// Bus slave.
	// ****************************************************************
	fumc_axil_slave u_slave
	(
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_clk_en(i_clk_en),
		.i_awvalid(i_awvalid),
		.i_awaddr(i_awaddr),
		.o_awready(o_awready),
		.i_wvalid(i_wvalid),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.o_wready(o_wready),
		.o_bvalid(o_bvalid),
		.o_bresp(o_bresp),
		.i_bready(i_bready),
		.i_arvalid(i_arvalid),
		.i_araddr(i_araddr),
		.o_arready(o_arready),
		.o_rvalid(o_rvalid),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.i_rready(i_rready),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_wr_strb(wr_strb),
		.i_wr_resp(wr_resp),
		.o_rd_en(rd_en),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data),
		.i_rd_resp(rd_resp)
	);

	// ****************************************************************
	// Write decode.
	// ****************************************************************
	assign pin = i_write_enable_pin;
	assign err = mode_reg[`FUMC_BIT_ERROR];
	assign swe = mode_reg[`FUMC_BIT_SWE];
	assign esu = mode_reg[`FUMC_BIT_ESU];
	assign psu = mode_reg[`FUMC_BIT_PSU];
	assign wr_mapped = (wr_addr == `FUMC_OFS_MODE) || (wr_addr == `FUMC_OFS_LOW_BLOCK)
		|| (wr_addr == `FUMC_OFS_STATUS);
	assign wr_resp = wr_mapped ? FUMC_OKAY : FUMC_SLVERR;
	assign mode_wr = wr_en && wr_strb && (wr_addr == `FUMC_OFS_MODE) && !i_flash_disabled;
	assign low_wr = wr_en && wr_strb && (wr_addr == `FUMC_OFS_LOW_BLOCK) && !i_flash_disabled;

	// ****************************************************************
	// Mode register next value.
	// ****************************************************************
	// enable write gate
	assign swe_wr_ok = mode_wr && pin;
	assign setup_wr_ok = mode_wr && pin && swe;
	assign mode_clear = !pin || i_sw_standby || i_hw_standby;
	assign err_next = i_op_fail || (err && !i_hw_standby);
	assign swe_next = mode_clear ? 1'b0 : (swe_wr_ok ? wr_data[`FUMC_BIT_SWE] : swe);
	assign bit_wr_ok[5:2] = {4{setup_wr_ok}};
	assign bit_wr_ok[`FUMC_BIT_E] = setup_wr_ok && esu && !err;
	assign bit_wr_ok[`FUMC_BIT_P] = setup_wr_ok && psu && !err;
	assign bit_kill[5:2] = 4'h0;
	assign bit_kill[1:0] = {2{err_next}};

	generate
		genvar k;
		for (k = 0; k < 6; k = k + 1)
		begin : g_mode_bit
			assign mode_low_next[k] = (mode_clear || !swe_next || bit_kill[k]) ? 1'b0
				: (bit_wr_ok[k] ? wr_data[k] : mode_reg[k]);
		end
	endgenerate

	assign mode_next = {err_next, swe_next, mode_low_next};

	// ****************************************************************
	// Low block select next value.
	// ****************************************************************
	fumc_onehot_guard u_guard
	(
		.i_selects({i_high_block_select, low_reg}),
		.o_multi(multi)
	);

	assign low_clear = !pin || !i_lower_sw_enable || i_sw_standby || i_hw_standby || multi;
	assign low_wr_ok = low_wr && pin && i_lower_sw_enable;
	assign low_next = low_clear ? `FUMC_LOW_BLOCK_RESET : (low_wr_ok ? wr_data : low_reg);

	// ****************************************************************
	// Registers.
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			mode_reg <= `FUMC_MODE_RESET;
			low_reg <= `FUMC_LOW_BLOCK_RESET;
			clear_both_reg <= 1'b0;
			hold_high_reg <= 1'b1;
		end
		else if (i_clk_en)
		begin
			mode_reg <= mode_next;
			low_reg <= low_next;
			clear_both_reg <= multi;
			hold_high_reg <= !swe_next;
		end
	end

	// ****************************************************************
	// Read decode.
	// ****************************************************************
	assign rd_mapped = (rd_addr == `FUMC_OFS_MODE) || (rd_addr == `FUMC_OFS_LOW_BLOCK)
		|| (rd_addr == `FUMC_OFS_STATUS);
	assign rd_resp = rd_mapped ? FUMC_OKAY : FUMC_SLVERR;
	assign rd_data = i_flash_disabled ? `FUMC_BYTE_ZERO
		: (rd_addr == `FUMC_OFS_MODE) ? mode_reg
		: (rd_addr == `FUMC_OFS_LOW_BLOCK) ? low_reg
		: (rd_addr == `FUMC_OFS_STATUS) ? {pin, 6'h00, clear_both_reg}
		: `FUMC_BYTE_ZERO;

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign o_upper_mode = mode_reg;
	assign o_low_block_select = low_reg;
	assign o_error_protect = err;
	assign o_clear_both = clear_both_reg;
	assign o_hold_high_nibble = hold_high_reg;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	sequence s_erase_enter;
		$rose(mode_reg[`FUMC_BIT_E]);
	endsequence

	sequence s_program_enter;
		$rose(mode_reg[`FUMC_BIT_P]);
	endsequence

	sequence s_verify_enter;
		$rose(mode_reg[`FUMC_BIT_EV]) or $rose(mode_reg[`FUMC_BIT_PV]);
	endsequence

	sequence s_disabled_read;
		rd_en && i_clk_en && i_flash_disabled ##1 o_rvalid;
	endsequence

	a_erase_order: assert property (s_erase_enter |-> $past(esu) && $past(swe) && !err)
		else $error("Erase bit set without erase setup.");

	a_erase_gate: assert property (s_erase_enter |-> $past(mode_wr) && $past(pin))
		else $error("Erase bit set outside a gated write.");

	a_program_order: assert property (s_program_enter |-> $past(psu) && $past(swe))
		else $error("Program bit set without program setup.");

	a_program_gate: assert property (s_program_enter |-> $past(mode_wr) && $past(pin))
		else $error("Program bit set outside a gated write.");

	a_verify_order: assert property (s_verify_enter |-> $past(swe) && swe)
		else $error("Verify bit set without software enable.");

	a_pin_low_clear: assert property (i_clk_en && !pin |=> mode_reg[6:0] == 7'h00)
		else $error("Mode bits not cleared with pin low.");

	a_error_sticky: assert property (i_clk_en && err && !i_hw_standby |=> err)
		else $error("Error flag lost outside hardware standby.");

	a_error_set: assert property (i_clk_en && i_op_fail |=> err ##1 (err || $past(i_hw_standby)))
		else $error("Error flag not set by a failure.");

	a_error_protect: assert property (err |-> !mode_reg[`FUMC_BIT_E] && !mode_reg[`FUMC_BIT_P])
		else $error("Program or erase active under error protection.");

	a_disabled_read: assert property (s_disabled_read |-> o_rdata == 32'h00000000)
		else $error("Read while disabled returned nonzero data.");

	a_enable_gate: assert property (i_clk_en && !pin |=> !swe)
		else $error("Software enable set with pin low.");

	a_setup_gate: assert property ((mode_reg[5:2] & ~$past(mode_reg[5:2])) != 4'h0
		|-> $past(setup_wr_ok))
		else $error("Setup or verify bit set outside a gated write.");

	a_standby_clear: assert property (i_clk_en && (i_sw_standby || i_hw_standby)
		|=> mode_reg[6:0] == 7'h00)
		else $error("Mode bits not cleared in standby.");

	a_low_clear: assert property (i_clk_en && (!pin || !i_lower_sw_enable) |=> low_reg == 8'h00)
		else $error("Low block register not cleared.");

	a_onehot_clear: assert property (i_clk_en && multi |=> low_reg == 8'h00 && o_clear_both)
		else $error("Multiple selects not cleared.");

	a_high_hold: assert property (o_hold_high_nibble == !swe)
		else $error("High nibble hold disagrees with enable.");

endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`include "fumc_map.svh"

module tb_top
	import fumc_pkg::*;
;
	// ****************************************************************
	// Signals.
	// ****************************************************************
	logic clk;
	logic nrst;
	logic awv;
	logic wv;
	logic bre;
	logic arv;
	logic rre;
	logic [7:0] awa;
	logic [7:0] ara;
	logic [31:0] wd;
	logic [3:0] ws;
	logic awr;
	logic wrdy;
	logic bv;
	logic arr;
	logic rv;
	logic [1:0] br;
	logic [1:0] rr;
	logic [31:0] rdat;
	logic pin;
	logic hws;
	logic sws;
	logic fdis;
	logic fail;
	logic lsw;
	logic cen;
	logic [3:0] wsel;
	logic [7:0] hsel;
	logic [7:0] umode;
	logic [7:0] lsel;
	logic eprot;
	logic clrb;
	logic hold;
	int fails;
	int comparisons;
	logic [31:0] rd_d;
	logic [1:0] rsp;
	logic [15:0] seq [0:11] = '{16'h2000, 16'h4040, 16'h4240, 16'h6060, 16'h6262, 16'h4040,
		16'h4140, 16'h5050, 16'h5151, 16'h4848, 16'h4444, 16'h0000};

	fumc_top DUT
	(
		.i_clock(clk), .i_nrst(nrst), .i_clk_en(cen),
		.i_awvalid(awv), .i_awaddr(awa), .o_awready(awr),
		.i_wvalid(wv), .i_wdata(wd), .i_wstrb(ws), .o_wready(wrdy),
		.o_bvalid(bv), .o_bresp(br), .i_bready(bre),
		.i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
		.o_rvalid(rv), .o_rdata(rdat), .o_rresp(rr), .i_rready(rre),
		.i_write_enable_pin(pin), .i_hw_standby(hws), .i_sw_standby(sws),
		.i_flash_disabled(fdis), .i_op_fail(fail),
		.i_lower_sw_enable(lsw), .i_high_block_select(hsel),
		.o_upper_mode(umode), .o_low_block_select(lsel), .o_error_protect(eprot),
		.o_clear_both(clrb), .o_hold_high_nibble(hold)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************************************
	// Bus and check tasks.
	// ****************************************************************
	task close_out;
		begin
			if (fails == 0 && comparisons > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		begin
			comparisons++;
			if (got !== exp)
			begin
				$display("Error %s expected %h seen %h", nm, exp, got);
				fails++;
			end
		end
	endtask

	task guard(input int n);
		begin
			if (n > 40)
			begin
				chk("bus_wait", 32'h0, 32'h1);
				close_out();
			end
		end
	endtask

	task tick(input int n);
		begin
			repeat (n) @(posedge clk);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic ta;
		logic tw;
		logic tb;
		begin
			@(posedge clk);
			awv <= 1'b1;
			awa <= a;
			wv <= 1'b1;
			wd <= {24'h0, d};
			ws <= wsel;
			bre <= 1'b1;
			n = 0;
			tb = 1'b0;
			while (!tb)
			begin
				@(negedge clk);
				ta = awv & awr;
				tw = wv & wrdy;
				tb = bv;
				rsp = br;
				n++;
				guard(n);
				@(posedge clk);
				if (ta) awv <= 1'b0;
				if (tw) wv <= 1'b0;
				if (tb) bre <= 1'b0;
			end
		end
	endtask

	task rd(input logic [7:0] a);
		int n;
		logic ta;
		logic tr;
		begin
			@(posedge clk);
			arv <= 1'b1;
			ara <= a;
			rre <= 1'b1;
			n = 0;
			tr = 1'b0;
			while (!tr)
			begin
				@(negedge clk);
				ta = arv & arr;
				tr = rv;
				rd_d = rdat;
				rsp = rr;
				n++;
				guard(n);
				@(posedge clk);
				if (ta) arv <= 1'b0;
				if (tr) rre <= 1'b0;
			end
		end
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		begin
			rd(a);
			chk(nm, {24'h0, e}, rd_d);
		end
	endtask

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial
	begin
		fails = 0;
		comparisons = 0;
		nrst = 1'b0;
		{awv, wv, bre, arv, rre, hws, sws, fdis, fail, lsw} = 10'h000;
		{awa, ara, hsel, wd, ws} = 60'h0;
		pin = 1'b1;
		cen = 1'b1;
		wsel = 4'hF;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		tick(2);
		rchk("mode", `FUMC_OFS_MODE, 8'h00);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h00);
		rchk("status", `FUMC_OFS_STATUS, 8'h80);
		chk("rresp", 32'h0, {30'h0, rsp});
		chk("hold", 32'h1, {31'h0, hold});
		foreach (seq[i])
		begin
			wr(`FUMC_OFS_MODE, seq[i][15:8]);
			rchk("mode", `FUMC_OFS_MODE, seq[i][7:0]);
			if (i == 4)
				chk("mode_port", 32'h62, {24'h0, umode});
		end
		wr(`FUMC_OFS_MODE, 8'h40);
		chk("hold", 32'h0, {31'h0, hold});
		pin <= 1'b0;
		tick(2);
		chk("mode_port", 32'h0, {24'h0, umode});
		rchk("status", `FUMC_OFS_STATUS, 8'h00);
		wr(`FUMC_OFS_MODE, 8'h40);
		rchk("mode", `FUMC_OFS_MODE, 8'h00);
		pin <= 1'b1;
		tick(2);
		wr(`FUMC_OFS_MODE, 8'h40);
		wr(`FUMC_OFS_MODE, 8'h50);
		wr(`FUMC_OFS_MODE, 8'h51);
		rchk("mode", `FUMC_OFS_MODE, 8'h51);
		fail <= 1'b1;
		tick(1);
		fail <= 1'b0;
		tick(2);
		rchk("mode", `FUMC_OFS_MODE, 8'hD0);
		chk("protect", 32'h1, {31'h0, eprot});
		wr(`FUMC_OFS_MODE, 8'h51);
		rchk("mode", `FUMC_OFS_MODE, 8'hD0);
		wr(`FUMC_OFS_MODE, 8'h00);
		rchk("mode", `FUMC_OFS_MODE, 8'h80);
		sws <= 1'b1;
		tick(1);
		sws <= 1'b0;
		tick(2);
		rchk("mode", `FUMC_OFS_MODE, 8'h80);
		wr(`FUMC_OFS_MODE, 8'h40);
		cen <= 1'b0;
		pin <= 1'b0;
		tick(2);
		chk("mode_frozen", 32'hC0, {24'h0, umode});
		pin <= 1'b1;
		cen <= 1'b1;
		tick(1);
		hws <= 1'b1;
		tick(1);
		hws <= 1'b0;
		tick(2);
		rchk("mode", `FUMC_OFS_MODE, 8'h00);
		lsw <= 1'b1;
		tick(2);
		wr(`FUMC_OFS_LOW_BLOCK, 8'h04);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h04);
		chk("low_port", 32'h04, {24'h0, lsel});
		wsel = 4'hE;
		wr(`FUMC_OFS_LOW_BLOCK, 8'h08);
		wsel = 4'hF;
		chk("bresp", 32'h0, {30'h0, rsp});
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h04);
		wr(`FUMC_OFS_LOW_BLOCK, 8'h03);
		tick(2);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h00);
		wr(`FUMC_OFS_LOW_BLOCK, 8'h80);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h80);
		hsel <= 8'h01;
		tick(1);
		@(negedge clk);
		chk("clear_both", 32'h1, {31'h0, clrb});
		chk("low_port", 32'h0, {24'h0, lsel});
		tick(1);
		hsel <= 8'h00;
		wr(`FUMC_OFS_LOW_BLOCK, 8'h01);
		lsw <= 1'b0;
		tick(2);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h00);
		lsw <= 1'b1;
		wr(`FUMC_OFS_LOW_BLOCK, 8'h10);
		fdis <= 1'b1;
		tick(2);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h00);
		wr(`FUMC_OFS_LOW_BLOCK, 8'h20);
		fdis <= 1'b0;
		tick(2);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h10);
		fail <= 1'b1;
		tick(1);
		fail <= 1'b0;
		tick(1);
		chk("protect", 32'h1, {31'h0, eprot});
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		tick(2);
		rchk("mode", `FUMC_OFS_MODE, 8'h00);
		rchk("low", `FUMC_OFS_LOW_BLOCK, 8'h00);
		rd(8'h0C);
		chk("rresp", 32'h2, {30'h0, rsp});
		wr(8'h0C, 8'hFF);
		chk("bresp", 32'h2, {30'h0, rsp});
		close_out();
	end
endmodule
